// *** mfp_irq_logic.v ***
`include "mfp_regs.vh"

// Contract
// - code 00: status pin drives active high
// - code 01: status pin drives active low
// - code 10: float idle, drive high asserted
// - code 11: float idle, drive low asserted
// - one weak-drive bit per pin, default normal
// - control code 00: plain AND term
// - control code 01: inverted AND term
// - control code 10: plain OR term
// - control code 11: inverted OR term
// - OR terms first, then AND with rest
// - single pin passes level or inverted level
// - function code 0x01 drives IO update
// - any-event plus three group outputs
// - loop0, loop1 and common event groups
// - unmasked event latches its status bit
// - mask per status bit, reset blocks
// - event seen while masked is dropped, not held pending
// - self-clearing clear bit per status bit
// - group output holds until sources cleared
// - group clear: all, common, loop0, loop1
// - control pin may clear an event group
// - status, mask, clear banks of twenty bytes
// - two-bit modifiers, four pins per byte
// - mode bit 7 selects control or status
// - eight-bit function code per pin
module mfp_irq_logic #(
  parameter NUM_BYTES = `MFP_BANK_BYTES,
  parameter LOOP0_FIRST = `MFP_LOOP0_FIRST_BYTE,
  parameter LOOP0_LAST = `MFP_LOOP0_LAST_BYTE,
  parameter LOOP1_FIRST = `MFP_LOOP1_FIRST_BYTE,
  parameter LOOP1_LAST = `MFP_LOOP1_LAST_BYTE
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_BYTES*8-1:0] evtIn,
  input wire [6:0] pinIn,
  output reg [6:0] pinOut,
  output reg [6:0] pinOe,
  output reg [6:0] pinWeak,
  output reg irqAny,
  output reg irqCommon,
  output reg irqLoop0,
  output reg irqLoop1,
  output reg ioUpdate
);

  localparam NEVT = NUM_BYTES * 8;

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [NEVT-1:0] status_r;
  reg [NEVT-1:0] mask_r;
  reg [NEVT-1:0] clear_r;
  reg [13:0] modifier_r;
  reg [6:0] role_r;
  reg [6:0] weak_r;
  reg [7:0] code_r [0:6];
  reg [3:0] groupClr_r;
  reg [6:0] pinSync1_r;
  reg [6:0] pinSync2_r;
  reg ioCtrl_r;
  reg [NEVT-1:0] status_nxt;
  reg [NEVT-1:0] clearVec;
  reg [7:0] rdByte;
  reg hit;
  reg [55:0] codeFlat;
  reg [6:0] outNxt;
  reg [6:0] oeNxt;
  reg stAsserted;
  integer p;
  integer cf;
  integer rp;

  wire [NEVT-1:0] loop0Map;
  wire [NEVT-1:0] loop1Map;
  wire [NEVT-1:0] commonMap;
  wire [13:0] idx = paddr[15:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire access = psel & penable & pready;
  wire wrEn = access & pwrite;
  wire [13:0] statOff = idx - `MFP_IDX_STATUS_BASE;
  wire [13:0] maskOff = idx - `MFP_IDX_MASK_BASE;
  wire [13:0] clrOff = idx - `MFP_IDX_CLEAR_BASE;
  wire [13:0] modeOff = idx - `MFP_IDX_MODE_BASE;
  wire [13:0] codeOff = idx - `MFP_IDX_CODE_BASE;
  wire inStat = aligned && (idx >= `MFP_IDX_STATUS_BASE) && (statOff < NUM_BYTES);
  wire inMask = aligned && (idx >= `MFP_IDX_MASK_BASE) && (maskOff < NUM_BYTES);
  wire inClr = aligned && (idx >= `MFP_IDX_CLEAR_BASE) && (clrOff < NUM_BYTES);
  wire inMode = aligned && (idx >= `MFP_IDX_MODE_BASE) && (modeOff < `MFP_PIN_COUNT);
  wire inCode = aligned && (idx >= `MFP_IDX_CODE_BASE) && (codeOff < `MFP_PIN_COUNT);
  wire [4:0] statK = statOff[4:0];
  wire [4:0] maskK = maskOff[4:0];
  wire [4:0] clrK = clrOff[4:0];
  wire [2:0] modeK = modeOff[2:0];
  wire [2:0] codeK = codeOff[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // event group maps by byte range
  genvar g;
  generate
    for (g = 0; g < NEVT; g = g + 1) begin : grpMap
      assign loop0Map[g] = (g / 8 >= LOOP0_FIRST) && (g / 8 <= LOOP0_LAST);
      assign loop1Map[g] = (g / 8 >= LOOP1_FIRST) && (g / 8 <= LOOP1_LAST);
      assign commonMap[g] = ~loop0Map[g] & ~loop1Map[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // combine control pins assigned to one function
  function ctrlEval;
    input [55:0] codes;
    input [13:0] mods;
    input [6:0] roles;
    input [6:0] lvl;
    input [7:0] target;
    integer i;
    reg anyPin;
    reg orSeen;
    reg orRes;
    reg andRes;
    reg term;
    begin
      anyPin = 1'b0;
      orSeen = 1'b0;
      orRes = 1'b0;
      andRes = 1'b1;
      for (i = 0; i < 7; i = i + 1) begin
        if (!roles[i] && codes[i*8 +: 8] == target) begin
          anyPin = 1'b1;
          term = lvl[i] ^ mods[2*i];
          if (mods[2*i+1]) begin
            orSeen = 1'b1;
            orRes = orRes | term;
          end else begin
            andRes = andRes & term;
          end
        end
      end
      ctrlEval = anyPin & andRes & (orRes | ~orSeen);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // flatten codes for the combiner
  always @* begin
    for (cf = 0; cf < 7; cf = cf + 1) begin
      codeFlat[cf*8 +: 8] = code_r[cf];
    end
  end

  wire pinClrAll = ctrlEval(codeFlat, modifier_r, role_r, pinSync2_r, `MFP_CTRL_CLR_ALL);
  wire pinClrCom = ctrlEval(codeFlat, modifier_r, role_r, pinSync2_r, `MFP_CTRL_CLR_COMMON);
  wire pinClrL0 = ctrlEval(codeFlat, modifier_r, role_r, pinSync2_r, `MFP_CTRL_CLR_LOOP0);
  wire pinClrL1 = ctrlEval(codeFlat, modifier_r, role_r, pinSync2_r, `MFP_CTRL_CLR_LOOP1);
  wire ioCtrl = ctrlEval(codeFlat, modifier_r, role_r, pinSync2_r, `MFP_CTRL_IO_UPDATE);
  wire gWrite = wrEn && aligned && (idx == `MFP_IDX_GROUP_CLEAR);
  wire gAll = (gWrite & pwdata[`MFP_GCLR_ALL_BIT]) | pinClrAll;
  wire gCom = (gWrite & pwdata[`MFP_GCLR_COMMON_BIT]) | pinClrCom;
  wire gL0 = (gWrite & pwdata[`MFP_GCLR_LOOP0_BIT]) | pinClrL0;
  wire gL1 = (gWrite & pwdata[`MFP_GCLR_LOOP1_BIT]) | pinClrL1;

  ////////////////////////////////////////////////////////////////////////////
  // status next value: set wins over clear
  always @* begin
    clearVec = {NEVT{gAll}} | ({NEVT{gCom}} & commonMap);
    clearVec = clearVec | ({NEVT{gL0}} & loop0Map) | ({NEVT{gL1}} & loop1Map);
    if (wrEn && inClr) begin
      clearVec[clrK*8 +: 8] = clearVec[clrK*8 +: 8] | pwdata[7:0];
    end
    status_nxt = (status_r & ~clearVec) | (evtIn & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  always @* begin
    rdByte = 8'h00;
    hit = 1'b1;
    if (inStat) begin
      rdByte = status_r[statK*8 +: 8];
    end else if (inMask) begin
      rdByte = mask_r[maskK*8 +: 8];
    end else if (inClr) begin
      rdByte = clear_r[clrK*8 +: 8];
    end else if (inMode) begin
      rdByte = {role_r[modeK], 7'h00};
    end else if (inCode) begin
      rdByte = code_r[codeK];
    end else if (aligned && idx == `MFP_IDX_MODIFIER_LO) begin
      rdByte = modifier_r[7:0];
    end else if (aligned && idx == `MFP_IDX_MODIFIER_HI) begin
      rdByte = {2'h0, modifier_r[13:8]};
    end else if (aligned && idx == `MFP_IDX_DRIVE) begin
      rdByte = {1'b0, weak_r};
    end else if (aligned && idx == `MFP_IDX_GROUP_CLEAR) begin
      rdByte = {4'h0, groupClr_r};
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, registered answer
  always @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~hit;
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge clk) begin
    if (sys_rst) begin
      mask_r <= {NEVT{1'b0}};
      modifier_r <= 14'h0000;
      role_r <= 7'h00;
      weak_r <= 7'h00;
      for (rp = 0; rp < 7; rp = rp + 1) begin
        code_r[rp] <= `MFP_RST_BYTE;
      end
    end else if (wrEn) begin
      if (inMask) begin
        mask_r[maskK*8 +: 8] <= pwdata[7:0];
      end
      if (inMode) begin
        role_r[modeK] <= pwdata[`MFP_MODE_ROLE_BIT];
      end
      if (inCode) begin
        code_r[codeK] <= pwdata[7:0];
      end
      if (aligned && idx == `MFP_IDX_MODIFIER_LO) begin
        modifier_r[7:0] <= pwdata[7:0];
      end
      if (aligned && idx == `MFP_IDX_MODIFIER_HI) begin
        modifier_r[13:8] <= pwdata[5:0];
      end
      if (aligned && idx == `MFP_IDX_DRIVE) begin
        weak_r <= pwdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status bank and self-clearing clear bits
  always @(posedge clk) begin
    if (sys_rst) begin
      status_r <= {NEVT{1'b0}};
      clear_r <= {NEVT{1'b0}};
      groupClr_r <= 4'h0;
    end else begin
      status_r <= status_nxt;
      clear_r <= {NEVT{1'b0}};
      if (wrEn && inClr) begin
        clear_r[clrK*8 +: 8] <= pwdata[7:0];
      end
      groupClr_r <= gWrite ? pwdata[3:0] : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aggregate interrupt outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      irqAny <= 1'b0;
      irqCommon <= 1'b0;
      irqLoop0 <= 1'b0;
      irqLoop1 <= 1'b0;
    end else begin
      irqAny <= |status_r;
      irqCommon <= |(status_r & commonMap);
      irqLoop0 <= |(status_r & loop0Map);
      irqLoop1 <= |(status_r & loop1Map);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control pin synchronizer and io update edge
  always @(posedge clk) begin
    if (sys_rst) begin
      pinSync1_r <= 7'h00;
      pinSync2_r <= 7'h00;
      ioCtrl_r <= 1'b0;
      ioUpdate <= 1'b0;
    end else begin
      pinSync1_r <= pinIn;
      pinSync2_r <= pinSync1_r;
      ioCtrl_r <= ioCtrl;
      ioUpdate <= ioCtrl & ~ioCtrl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status pin drivers
  always @* begin
    outNxt = 7'h00;
    oeNxt = 7'h00;
    stAsserted = 1'b0;
    for (p = 0; p < 7; p = p + 1) begin
      case (code_r[p])
        `MFP_STAT_ANY: stAsserted = irqAny;
        `MFP_STAT_COMMON: stAsserted = irqCommon;
        `MFP_STAT_LOOP0: stAsserted = irqLoop0;
        `MFP_STAT_LOOP1: stAsserted = irqLoop1;
        default: stAsserted = 1'b0;
      endcase
      if (role_r[p]) begin
        case (modifier_r[2*p +: 2])
          `MFP_SMOD_CMOS_HIGH: begin
            outNxt[p] = stAsserted;
            oeNxt[p] = 1'b1;
          end
          `MFP_SMOD_CMOS_LOW: begin
            outNxt[p] = ~stAsserted;
            oeNxt[p] = 1'b1;
          end
          `MFP_SMOD_OD_HIGH: begin
            outNxt[p] = 1'b1;
            oeNxt[p] = stAsserted;
          end
          default: begin
            outNxt[p] = 1'b0;
            oeNxt[p] = stAsserted;
          end
        endcase
      end
    end
  end

  // registered pin outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      pinOut <= 7'h00;
      pinOe <= 7'h00;
      pinWeak <= 7'h00;
    end else begin
      pinOut <= outNxt;
      pinOe <= oeNxt;
      pinWeak <= weak_r;
    end
  end

endmodule

// *** mfp_regs.vh ***
`ifndef MFP_REGS_VH
`define MFP_REGS_VH

// register indices; byte address is four times the index
`define MFP_IDX_MODIFIER_LO 14'h0100
`define MFP_IDX_MODIFIER_HI 14'h0101
`define MFP_IDX_MODE_BASE 14'h0102
`define MFP_IDX_DRIVE 14'h0109
`define MFP_IDX_MASK_BASE 14'h010c
`define MFP_IDX_CODE_BASE 14'h0182
`define MFP_IDX_GROUP_CLEAR 14'h2005
`define MFP_IDX_CLEAR_BASE 14'h2006
`define MFP_IDX_STATUS_BASE 14'h300b

// bank and pin sizes
`define MFP_BANK_BYTES 20
`define MFP_PIN_COUNT 7

// field positions
`define MFP_MODE_ROLE_BIT 7
`define MFP_GCLR_ALL_BIT 0
`define MFP_GCLR_COMMON_BIT 1
`define MFP_GCLR_LOOP0_BIT 2
`define MFP_GCLR_LOOP1_BIT 3

// control function codes
`define MFP_CTRL_IO_UPDATE 8'h01
`define MFP_CTRL_CLR_ALL 8'h20
`define MFP_CTRL_CLR_COMMON 8'h21
`define MFP_CTRL_CLR_LOOP0 8'h22
`define MFP_CTRL_CLR_LOOP1 8'h23

// status function codes
`define MFP_STAT_ANY 8'h00
`define MFP_STAT_COMMON 8'h01
`define MFP_STAT_LOOP0 8'h02
`define MFP_STAT_LOOP1 8'h03

// status modifier codes
`define MFP_SMOD_CMOS_HIGH 2'h0
`define MFP_SMOD_CMOS_LOW 2'h1
`define MFP_SMOD_OD_HIGH 2'h2
`define MFP_SMOD_OD_LOW 2'h3

// default group byte ranges inside the status bank
`define MFP_LOOP0_FIRST_BYTE 8
`define MFP_LOOP0_LAST_BYTE 13
`define MFP_LOOP1_FIRST_BYTE 14
`define MFP_LOOP1_LAST_BYTE 19

// reset values
`define MFP_RST_BYTE 8'h00

`endif

// *** mfp_irq_checker_assertions.sv ***
module mfp_irq_checker #(
  parameter NUM_BYTES = 20
) (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [NUM_BYTES*8-1:0] evtIn,
  input wire [6:0] pinOe,
  input wire [6:0] pinWeak,
  input wire irqAny,
  input wire irqCommon,
  input wire irqLoop0,
  input wire irqLoop1,
  input wire ioUpdate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // completed write and last drive value
  wire wrDone = psel && penable && pready && pwrite;
  reg [6:0] weakSeen_r;
  always @(posedge clk) begin
    if (wrDone && paddr == 16'h0424) weakSeen_r <= pwdata[6:0];
  end
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_reset_quiet: assert property (disable iff (1'h0) sys_rst |=>
    !pready && pinOe == 7'h00 && !irqAny && !ioUpdate) else $error("reset state");
  a_irq_any_or: assert property (irqAny == (irqCommon || irqLoop0 || irqLoop1))
    else $error("any not or of groups");
  a_update_pulse: assert property (ioUpdate |=> !ioUpdate)
    else $error("update not a pulse");
  a_weak_follows: assert property (wrDone && paddr == 16'h0424 |-> ##2
    pinWeak == weakSeen_r) else $error("weak drive mismatch");
  a_gclr_all: assert property (wrDone && paddr == 16'h8014 && pwdata[0]
    && evtIn == '0 ##1 evtIn == '0 |=> !irqAny) else $error("group clear missed");
  c_update: cover property (ioUpdate);
  c_err: cover property (pslverr);
  c_loops: cover property (irqLoop0 && irqLoop1);
endmodule

bind mfp_irq_logic mfp_irq_checker #(.NUM_BYTES(NUM_BYTES)) mfp_irq_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
  .pinOe(pinOe), .pinWeak(pinWeak), .irqAny(irqAny), .irqCommon(irqCommon),
  .irqLoop0(irqLoop0), .irqLoop1(irqLoop1), .ioUpdate(ioUpdate));

// *** mfp_pin_partner.sv ***
module mfp_pin_partner (
  input wire [6:0] pinOut,
  input wire [6:0] pinOe,
  input wire [6:0] drvVal,
  input wire [6:0] drvEn,
  input wire [6:0] pullUp,
  output wire [6:0] pinLvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // device drive wins, then external logic, then the resistor
  assign pinLvl = (pinOe & pinOut) | (~pinOe & drvEn & drvVal)
    | (~pinOe & ~drvEn & pullUp);
endmodule

// *** mfp_irq_logic_tb.sv ***
module mfp_irq_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sysRst, psel, penable, pwrite, pready, pslverr, rerr;
  logic irqAny, irqCommon, irqLoop0, irqLoop1, ioUpdate;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [159:0] evtIn;
  logic [6:0] pinIn, pinOut, pinOe, pinWeak, drvVal;
  int nFail = 0;
  int nTests = 0;
  int nUpd = 0;
  int c0;
  mfp_irq_logic mfp_irq_logic_inst (.clk(clk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evtIn(evtIn), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinWeak(pinWeak), .irqAny(irqAny), .irqCommon(irqCommon),
    .irqLoop0(irqLoop0), .irqLoop1(irqLoop1), .ioUpdate(ioUpdate));
  // pin 4 is left to the device, pulled up when floating
  mfp_pin_partner mfp_pin_partner_inst (.pinOut(pinOut), .pinOe(pinOe), .drvVal(drvVal),
    .drvEn(7'h6f), .pullUp(7'h10), .pinLvl(pinIn));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // count update pulses
  always @(posedge clk) begin
    if (ioUpdate === 1'h1) nUpd <= nUpd + 1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task evt(input int b);
    @(posedge clk);
    evtIn <= 160'h1 << b;
    @(posedge clk);
    evtIn <= '0;
  endtask
  task printVerdict;
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200us;
    nFail++;
    printVerdict;
  end
  ////////////////////////////////////////
  initial begin
    sysRst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    evtIn = '0;
    drvVal = 7'h02;
    tick(8);
    sysRst <= 1'h0;
    rd(16'h0424, 32'h0);
    rd(16'h0430, 32'h0);
    wr(16'h0424, 32'h55);
    rd(16'h0424, 32'h55);
    chk(pinWeak, 32'h55);
    apb(1'h0, 16'h0002, 32'h0);
    chk(rerr, 32'h1);
    evt(0);
    tick(3);
    chk(irqAny, 32'h0);
    // unmask one event in each group
    wr(16'h0430, 32'h1);
    evt(0);
    wr(16'h0450, 32'h1);
    evt(64);
    wr(16'h0468, 32'h80);
    evt(119);
    tick(3);
    rd(16'hc02c, 32'h1);
    chk({irqAny, irqCommon, irqLoop0, irqLoop1}, 32'hf);
    wr(16'hc02c, 32'h0);
    rd(16'hc02c, 32'h1);
    // pin 4 as status of any event, asserted
    wr(16'h0418, 32'h80);
    wr(16'h0618, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(16'h0404, 32'h20 | m);
      tick(2);
      chk({pinOe[4], pinOut[4]}, {1'h1, ~m[0]});
    end
    wr(16'h8018, 32'h1);
    tick(2);
    rd(16'h8018, 32'h0);
    rd(16'hc02c, 32'h0);
    chk({irqAny, irqCommon}, 32'h2);
    wr(16'h8014, 32'h4);
    tick(2);
    chk({irqLoop0, irqLoop1}, 32'h1);
    rd(16'hc064, 32'h80);
    wr(16'h8014, 32'h1);
    tick(2);
    chk(irqAny, 32'h0);
    // pin 1 inverted, clears all from outside
    evt(0);
    wr(16'h0400, 32'h74);
    wr(16'h060c, 32'h20);
    drvVal[1] <= 1'h0;
    tick(5);
    chk(irqAny, 32'h0);
    drvVal[1] <= 1'h1;
    for (int m = 0; m < 4; m++) begin
      wr(16'h0404, 32'h20 | m);
      tick(2);
      chk({pinOe[4], pinOe[4] & pinOut[4]}, {m < 2, m == 1});
    end
    // pins 0, 2, 3 and 6 combined into io update
    wr(16'h0608, 32'h1);
    wr(16'h0610, 32'h1);
    wr(16'h0614, 32'h1);
    wr(16'h0620, 32'h1);
    for (int v = 0; v < 16; v++) begin
      drvVal <= {v[3], 2'h0, v[2], v[1], 2'h2};
      tick(5);
      c0 = nUpd;
      drvVal[0] <= v[0];
      tick(6);
      chk(nUpd-c0, v[0]&~v[2]&(~v[1]|v[3]));
    end
    printVerdict;
  end
endmodule
